// File: mcd_core.v
// execution block for clear, complement, decrement, compare and
// clear-watchdog ops, with working register, 128-byte file, flags and
// a small watchdog, all reached over an AXI4-Lite slave port
// assumes one clock (ref_clk, 40 MHz) and a well-behaved AXI master
//
// Summary of operation
// - clearing the working register loads zero and sets the zero flag in one cycle.
// - clearing the watchdog zeroes its counter and also the prescaler when it serves the watchdog.
// - clearing the watchdog sets the timeout and power-down status bits to one in one cycle.
// - clearing a file register (address 0..127) writes zero there and sets the zero flag.
// - complement inverts the file register and sets the zero flag from the result in one cycle.
// - for complement and decrement, dest 0 sends the result to the working register, 1 back to the file.
// - decrement subtracts one from the file register and sets the zero flag from the result in one cycle.
// - compare subtracts the working register from the file register and updates zero and carry in one cycle.
// - compare changes neither the working register nor the file register, only the flags.
`timescale 1ns/100ps
`default_nettype none
`include "mcd_defines.vh"

module mcd_core (
    input  wire        ref_clk,
    input  wire        rstn,
    input  wire [31:0] s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [31:0] s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready
);

    // ****************************************
    // state
    // ****************************************
    reg  [7:0]  file_mem [0:127];
    reg  [7:0]  work_register;
    reg         zero_flag;
    reg         carry_flag;
    reg         timeout_status_n;
    reg         powerdown_status_n;
    reg  [6:0]  file_ptr;
    reg  [1:0]  wd_cfg;
    reg  [11:0] last_cmd;
    reg  [4:0]  wr_addr;
    reg  [31:0] wr_data;
    reg  [3:0]  wr_strb;
    reg         aw_held;
    reg         w_held;
    reg  [31:0] next_rdata;
    reg  [1:0]  next_rresp;

    wire        do_write;
    wire        wr_low;
    wire        wr_cmd;
    wire [3:0]  op;
    wire [6:0]  op_adr;
    wire        op_dest;
    wire [7:0]  op_fval;
    wire [7:0]  alu_result;
    wire        alu_to_work;
    wire        alu_to_file;
    wire        alu_zero_we;
    wire        alu_zero;
    wire        alu_carry_we;
    wire        alu_carry;
    wire        clear_watchdog_op;
    wire        sleep_op;
    wire        wd_run;
    wire        ps_to_wd;
    wire        ps_wrap;
    wire        wd_wrap;
    wire [7:0]  shared_prescaler;
    wire [7:0]  watchdog_counter;

    // ****************************************
    // write channel capture
    // ****************************************
    // address and data are taken in either order, then held until the response
    always @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `MCD_RESP_OKAY;
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            wr_addr       <= 5'h00;
            wr_data       <= 32'h0000_0000;
            wr_strb       <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held       <= 1'b1;
                s_axi_awready <= 1'b0;
                wr_addr       <= s_axi_awaddr[4:0];
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held       <= 1'b1;
                s_axi_wready <= 1'b0;
                wr_data      <= s_axi_wdata;
                wr_strb      <= s_axi_wstrb;
            end
            if (do_write)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (wr_addr[1:0] != 2'h0 || wr_addr > `MCD_REG_WDCNT) ?
                                `MCD_RESP_SLVERR : `MCD_RESP_OKAY;
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid  <= 1'b0;
                aw_held       <= 1'b0;
                w_held        <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // the write acts once, in the cycle both halves are present
    assign do_write = aw_held & w_held & ~s_axi_bvalid;
    assign wr_low   = do_write & wr_strb[0];
    // a command needs both low byte lanes, or its fields would be torn
    assign wr_cmd   = do_write & (wr_addr == `MCD_REG_CMD) & (&wr_strb[1:0]);

    // ****************************************
    // command decode and datapath
    // ****************************************
    assign op      = wr_cmd ? wr_data[`MCD_CMD_OP_MSB:`MCD_CMD_OP_LSB] : `MCD_OP_NONE;
    assign op_adr  = wr_data[`MCD_CMD_ADR_MSB:`MCD_CMD_ADR_LSB];
    assign op_dest = wr_data[`MCD_CMD_DEST];
    assign op_fval = file_mem[op_adr];

    assign clear_watchdog_op = (op == `MCD_OP_CLR_WDOG);
    assign sleep_op          = (op == `MCD_OP_SLEEP);

    mcd_alu u_alu (
        .op       (op),
        .dest     (op_dest),
        .work     (work_register),
        .fval     (op_fval),
        .result   (alu_result),
        .to_work  (alu_to_work),
        .to_file  (alu_to_file),
        .zero_we  (alu_zero_we),
        .zero     (alu_zero),
        .carry_we (alu_carry_we),
        .carry    (alu_carry)
    );

    // ****************************************
    // file register array
    // ****************************************
    // no reset on the array, like any ram; op and direct writes never collide
    always @(posedge ref_clk)
    begin
        if (alu_to_file)
            file_mem[op_adr] <= alu_result;
        else if (wr_low && wr_addr == `MCD_REG_FDATA)
            file_mem[file_ptr] <= wr_data[7:0];
    end

    // ****************************************
    // working register, flags, config
    // ****************************************
    always @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            work_register <= `MCD_RST_WORK;
            zero_flag     <= 1'b0;
            carry_flag    <= 1'b0;
            file_ptr      <= 7'h00;
            wd_cfg        <= `MCD_RST_CFG;
            last_cmd      <= 12'h000;
        end
        else
        begin
            if (wr_cmd)
                last_cmd <= wr_data[11:0];
            // ops take priority over direct software writes of the same cycle
            if (alu_to_work)
                work_register <= alu_result;
            else if (wr_low && wr_addr == `MCD_REG_WORK)
                work_register <= wr_data[7:0];
            if (alu_zero_we)
                zero_flag <= alu_zero;
            else if (wr_low && wr_addr == `MCD_REG_STATUS)
                zero_flag <= wr_data[`MCD_ST_ZERO];
            if (alu_carry_we)
                carry_flag <= alu_carry;
            else if (wr_low && wr_addr == `MCD_REG_STATUS)
                carry_flag <= wr_data[`MCD_ST_CARRY];
            if (wr_low && wr_addr == `MCD_REG_FADDR)
                file_ptr <= wr_data[6:0];
            if (wr_low && wr_addr == `MCD_REG_WDCFG)
                wd_cfg <= wr_data[1:0];
        end
    end

    // ****************************************
    // watchdog and shared prescaler
    // ****************************************
    assign wd_run   = wd_cfg[`MCD_CFG_WD_EN];
    assign ps_to_wd = wd_cfg[`MCD_CFG_PS_WDOG];

    // prescaler runs always; it only clocks the watchdog while assigned to it
    mcd_counter #(.W(8)) u_prescaler (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .clr     (clear_watchdog_op & ps_to_wd),
        .en      (1'b1),
        .count   (shared_prescaler),
        .wrap    (ps_wrap)
    );

    mcd_counter #(.W(8)) u_watchdog (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .clr     (clear_watchdog_op),
        .en      (wd_run & (ps_to_wd ? ps_wrap : 1'b1)),
        .count   (watchdog_counter),
        .wrap    (wd_wrap)
    );

    // status bits; a watchdog restart zeroes the counter so it cannot wrap then
    always @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            timeout_status_n   <= 1'b1;
            powerdown_status_n <= 1'b1;
        end
        else
        begin
            if (wd_wrap)
                timeout_status_n <= 1'b0;
            else if (clear_watchdog_op)
                timeout_status_n <= 1'b1;
            if (sleep_op)
                powerdown_status_n <= 1'b0;
            else if (clear_watchdog_op)
                powerdown_status_n <= 1'b1;
        end
    end

    // ****************************************
    // read channel
    // ****************************************
    // read mux, unmapped or misaligned addresses answer slverr
    always @*
    begin
        next_rdata = 32'h0000_0000;
        next_rresp = `MCD_RESP_OKAY;
        case (s_axi_araddr[4:0])
            `MCD_REG_CMD:    next_rdata[11:0] = last_cmd;
            `MCD_REG_WORK:   next_rdata[7:0]  = work_register;
            `MCD_REG_STATUS: next_rdata[3:0]  = {powerdown_status_n, timeout_status_n, carry_flag, zero_flag};
            `MCD_REG_FADDR:  next_rdata[6:0]  = file_ptr;
            `MCD_REG_FDATA:  next_rdata[7:0]  = file_mem[file_ptr];
            `MCD_REG_WDCFG:  next_rdata[1:0]  = wd_cfg;
            `MCD_REG_WDCNT:  next_rdata[15:0] = {shared_prescaler, watchdog_counter};
            default:         next_rresp       = `MCD_RESP_SLVERR;
        endcase
    end

    // one read at a time, answered the cycle after the address is taken
    always @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `MCD_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= next_rdata;
            s_axi_rresp   <= next_rresp;
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

endmodule // mcd_core

`default_nettype wire

// File: mcd_defines.vh
// constants for the clear/compare/decrement execution block
// assumes a 32-bit AXI4-Lite register port, byte addressed
`ifndef MCD_DEFINES_VH
`define MCD_DEFINES_VH

// ****************************************
// register byte offsets
// ****************************************
`define MCD_REG_CMD     5'h00
`define MCD_REG_WORK    5'h04
`define MCD_REG_STATUS  5'h08
`define MCD_REG_FADDR   5'h0c
`define MCD_REG_FDATA   5'h10
`define MCD_REG_WDCFG   5'h14
`define MCD_REG_WDCNT   5'h18

// ****************************************
// command register fields
// ****************************************
`define MCD_CMD_OP_LSB   0
`define MCD_CMD_OP_MSB   3
`define MCD_CMD_ADR_LSB  4
`define MCD_CMD_ADR_MSB  10
`define MCD_CMD_DEST     11

// ****************************************
// operation codes
// ****************************************
`define MCD_OP_NONE        4'h0
`define MCD_OP_CLR_WORK    4'h1
`define MCD_OP_CLR_WDOG    4'h2
`define MCD_OP_CLR_FILE    4'h3
`define MCD_OP_COMPLEMENT  4'h4
`define MCD_OP_DECREMENT   4'h5
`define MCD_OP_COMPARE     4'h6
`define MCD_OP_SLEEP       4'h7

// ****************************************
// status and watchdog config bits
// ****************************************
`define MCD_ST_ZERO      0
`define MCD_ST_CARRY     1
`define MCD_ST_TIMEOUT_N 2
`define MCD_ST_PWRDN_N   3
`define MCD_CFG_PS_WDOG  0
`define MCD_CFG_WD_EN    1

// ****************************************
// reset values and response codes
// ****************************************
`define MCD_RST_WORK     8'h00
`define MCD_RST_CFG      2'h0
`define MCD_RESP_OKAY    2'h0
`define MCD_RESP_SLVERR  2'h2

`endif

// File: mcd_counter.v
// free-running up counter with synchronous clear and wrap pulse
// assumes one clock, asynchronous active-low reset
`timescale 1ns/100ps
`default_nettype none

module mcd_counter #(
    parameter W = 8
) (
    input  wire         ref_clk,
    input  wire         rstn,
    input  wire         clr,
    input  wire         en,
    output reg  [W-1:0] count,
    output wire         wrap
);

    // wrap fires on the step from all ones back to zero
    assign wrap = en & ~clr & (&count);

    // clear beats counting so a restart never loses its zero
    always @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            count <= {W{1'b0}};
        else if (clr)
            count <= {W{1'b0}};
        else if (en)
            count <= count + {{(W-1){1'b0}}, 1'b1};
    end

endmodule // mcd_counter

`default_nettype wire

// File: mcd_alu.v
// combinational datapath for the clear/complement/decrement/compare ops
// assumes operands are stable for the cycle the op is issued
`timescale 1ns/100ps
`default_nettype none
`include "mcd_defines.vh"

module mcd_alu (
    input  wire [3:0] op,
    input  wire       dest,
    input  wire [7:0] work,
    input  wire [7:0] fval,
    output reg  [7:0] result,
    output reg        to_work,
    output reg        to_file,
    output reg        zero_we,
    output reg        zero,
    output reg        carry_we,
    output reg        carry
);

    reg [8:0] diff;

    // result, destination and flag selection per op
    always @*
    begin
        diff     = {1'b0, fval} - {1'b0, work};
        result   = 8'h00;
        to_work  = 1'b0;
        to_file  = 1'b0;
        zero_we  = 1'b0;
        zero     = 1'b0;
        carry_we = 1'b0;
        carry    = 1'b0;
        case (op)
            `MCD_OP_CLR_WORK:
            begin
                to_work = 1'b1;
                zero_we = 1'b1;
                zero    = 1'b1;
            end
            `MCD_OP_CLR_FILE:
            begin
                to_file = 1'b1;
                zero_we = 1'b1;
                zero    = 1'b1;
            end
            `MCD_OP_COMPLEMENT:
            begin
                result  = ~fval;
                to_work = ~dest;
                to_file = dest;
                zero_we = 1'b1;
                zero    = (result == 8'h00);
            end
            `MCD_OP_DECREMENT:
            begin
                result  = fval - 8'h01;
                to_work = ~dest;
                to_file = dest;
                zero_we = 1'b1;
                zero    = (result == 8'h00);
            end
            `MCD_OP_COMPARE:
            begin
                // difference is dropped, nothing is written back
                zero_we  = 1'b1;
                carry_we = 1'b1;
                zero     = (diff[7:0] == 8'h00);
                carry    = ~diff[8];
            end
            default:
            begin
                result = 8'h00;
            end
        endcase
    end

endmodule // mcd_alu

`default_nettype wire

// File: mcd_core_assertions.sv
// checker for the AXI4-Lite port and working-register clear of mcd_core
// assumes it is bound to mcd_core: one clock, async active-low reset
`timescale 1ns/100ps
`default_nettype none
`include "mcd_defines.vh"

module mcd_core_assertions (
    input wire logic        ref_clk,
    input wire logic        rstn,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready
);
    logic [4:0]  aw_q;
    logic [4:0]  ar_q;
    logic [31:0] w_q;
    logic        work_clr; // working register known to be zero

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);

    // ********
    // helper state
    // ********
    // flag is conservative: any other write to work or cmd drops it
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            aw_q     <= 5'h00;
            ar_q     <= 5'h00;
            w_q      <= 32'h0;
            work_clr <= 1'b1;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
                aw_q <= s_axi_awaddr[4:0];
            if (s_axi_wvalid && s_axi_wready)
                w_q <= s_axi_wdata;
            if (s_axi_arvalid && s_axi_arready)
                ar_q <= s_axi_araddr[4:0];
            if (s_axi_bvalid && s_axi_bready && aw_q == `MCD_REG_CMD)
                work_clr <= (w_q[3:0] == `MCD_OP_CLR_WORK);
            else if (s_axi_bvalid && s_axi_bready && aw_q == `MCD_REG_WORK)
                work_clr <= 1'b0;
        end
    end

    // ********
    // properties
    // ********
    sequence wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence b_answer;
        !s_axi_bvalid ##1 s_axi_bvalid;
    endsequence

    aw_block_a: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
        else $error("address ready stayed high after take");
    b_late_a: assert property (wr_take |=> b_answer)
        else $error("write response not two edges after take");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before ready");
    b_free_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
        else $error("write channel not freed after response");
    bad_write_a: assert property (s_axi_bvalid && (aw_q[1:0] != 2'h0 || aw_q > `MCD_REG_WDCNT)
        |-> s_axi_bresp == `MCD_RESP_SLVERR) else $error("bad write address not refused");
    r_late_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read data not one edge after take");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data changed before ready");
    r_free_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
        else $error("read channel not freed after data");
    bad_read_a: assert property (s_axi_arvalid && s_axi_arready && (s_axi_araddr[1:0] != 2'h0
        || s_axi_araddr[4:0] > `MCD_REG_WDCNT) |=> s_axi_rresp == `MCD_RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("bad read address not refused");
    clr_work_a: assert property (s_axi_rvalid && ar_q == `MCD_REG_WORK && work_clr |-> s_axi_rdata == 32'h0)
        else $error("working register not zero after clear");
endmodule // mcd_core_assertions

bind mcd_core mcd_core_assertions u_mcd_core_assertions (.ref_clk(ref_clk), .rstn(rstn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready));
`default_nettype wire

// File: mcu_clear_compare_decrement_ops_test.sv
// self-checking bench for mcd_core, driven over its AXI4-Lite port
// assumes mcd_core and mcd_defines.vh; no watchdog enable until that test
`timescale 1ns/100ps
`default_nettype none
`include "mcd_defines.vh"

module mcu_clear_compare_decrement_ops_test;
    logic        ref_clk = 1'b0;
    logic        rstn = 1'b0;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    int          n_fail = 0;
    int          num_checks = 0;
    logic [7:0]  fv [4] = '{8'h34, 8'h12, 8'h12, 8'h00};
    logic [7:0]  wv [4] = '{8'h12, 8'h12, 8'h34, 8'hff};

    mcd_core u_mcd_core (.ref_clk(ref_clk), .rstn(rstn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

    // 40 MHz clock
    always #12.5 ref_clk = ~ref_clk;

    // ********
    // shared tasks
    // ********
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // a bound that runs out ends the run as a failure
    task automatic hung(input int i);
        if (i >= 20)
        begin
            n_fail++;
            give_verdict();
        end
    endtask

    // address and data offered together, each dropped when taken
    task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
        int  i;
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        for (i = 0; i < 20 && !(aw_ok && w_ok); i++)
        begin
            @(posedge ref_clk);
            aw_ok = aw_ok | s_axi_awready;
            w_ok = w_ok | s_axi_wready;
            s_axi_awvalid <= !aw_ok;
            s_axi_wvalid <= !w_ok;
        end
        hung(i);
        s_axi_bready <= 1'b1;
        for (i = 0; i < 20 && !s_axi_bvalid; i++)
            @(posedge ref_clk);
        hung(i);
        check(s_axi_bresp, er);
        s_axi_bready <= 1'b0;
    endtask

    // read, then compare the masked word and the response
    task automatic rd(input logic [31:0] a, input logic [31:0] exp, input logic [31:0] m = 32'hffffffff,
                      input logic [1:0] er = 2'h0);
        int i;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        for (i = 0; i < 20 && !(s_axi_arvalid && s_axi_arready); i++)
            @(posedge ref_clk);
        hung(i);
        s_axi_arvalid <= 1'b0;
        s_axi_rready <= 1'b1;
        for (i = 0; i < 20 && !(s_axi_rvalid && s_axi_rready); i++)
            @(posedge ref_clk);
        hung(i);
        check(s_axi_rdata & m, exp);
        check(s_axi_rresp, er);
        s_axi_rready <= 1'b0;
    endtask

    task automatic op(input logic [3:0] code, input logic [6:0] adr, input logic dest);
        wr(`MCD_REG_CMD, {20'h0, dest, adr, code});
    endtask

    // file entry 5 and working register preset, flags forced to st
    task automatic prep(input logic [7:0] f, input logic [7:0] w, input logic [1:0] st);
        wr(`MCD_REG_FADDR, 32'h5);
        wr(`MCD_REG_FDATA, {24'h0, f});
        wr(`MCD_REG_WORK, {24'h0, w});
        wr(`MCD_REG_STATUS, {30'h0, st});
    endtask

    // ********
    // scenarios
    // ********
    task automatic t_reset;
        rd(`MCD_REG_WORK, 32'h0);
        rd(`MCD_REG_STATUS, 32'hc);
        rd(`MCD_REG_WDCFG, 32'h0);
    endtask

    task automatic t_clear;
        prep(8'h55, 8'h55, 2'h0);
        op(`MCD_OP_CLR_WORK, 7'h00, 1'b0);
        rd(`MCD_REG_WORK, 32'h0);
        rd(`MCD_REG_STATUS, 32'h1, 32'h1);
        wr(`MCD_REG_FADDR, 32'h7f);
        wr(`MCD_REG_FDATA, 32'h55);
        wr(`MCD_REG_STATUS, 32'h0);
        op(`MCD_OP_CLR_FILE, 7'h7f, 1'b0);
        rd(`MCD_REG_FDATA, 32'h0);
        rd(`MCD_REG_STATUS, 32'h1, 32'h1);
    endtask

    task automatic t_complement;
        prep(8'ha6, 8'h00, 2'h1);
        op(`MCD_OP_COMPLEMENT, 7'h05, 1'b1);
        rd(`MCD_REG_FDATA, 32'h59);
        rd(`MCD_REG_STATUS, 32'h0, 32'h1);
        op(`MCD_OP_COMPLEMENT, 7'h05, 1'b0);
        rd(`MCD_REG_WORK, 32'ha6);
        rd(`MCD_REG_FDATA, 32'h59);
        prep(8'hff, 8'h00, 2'h0);
        op(`MCD_OP_COMPLEMENT, 7'h05, 1'b1);
        rd(`MCD_REG_STATUS, 32'h1, 32'h1);
    endtask

    task automatic t_decrement;
        prep(8'h01, 8'h00, 2'h0);
        op(`MCD_OP_DECREMENT, 7'h05, 1'b1);
        rd(`MCD_REG_FDATA, 32'h0);
        rd(`MCD_REG_STATUS, 32'h1, 32'h1);
        prep(8'h00, 8'h33, 2'h1);
        op(`MCD_OP_DECREMENT, 7'h05, 1'b0);
        rd(`MCD_REG_WORK, 32'hff);
        rd(`MCD_REG_FDATA, 32'h0);
        rd(`MCD_REG_STATUS, 32'h0, 32'h1);
    endtask

    // flags preset to the inverse of the expected outcome
    task automatic t_compare;
        logic c;
        logic z;
        for (int k = 0; k < 4; k++)
        begin
            c = (fv[k] >= wv[k]);
            z = (fv[k] == wv[k]);
            prep(fv[k], wv[k], {!c, !z});
            op(`MCD_OP_COMPARE, 7'h05, 1'b0);
            rd(`MCD_REG_STATUS, {30'h0, c, z}, 32'h3);
            rd(`MCD_REG_WORK, {24'h0, wv[k]});
            rd(`MCD_REG_FDATA, {24'h0, fv[k]});
        end
    endtask

    // unassigned watchdog wraps after 256 cycles and drops timeout_n
    task automatic t_watchdog;
        wr(`MCD_REG_WDCFG, 32'h2);
        repeat (300) @(posedge ref_clk);
        rd(`MCD_REG_STATUS, 32'h8, 32'hc);
        op(`MCD_OP_SLEEP, 7'h00, 1'b0);
        rd(`MCD_REG_STATUS, 32'h0, 32'hc);
        wr(`MCD_REG_WDCFG, 32'h3);
        op(`MCD_OP_CLR_WDOG, 7'h00, 1'b0);
        rd(`MCD_REG_STATUS, 32'hc, 32'hc);
        rd(`MCD_REG_WDCNT, 32'h0, 32'hf8ff);
        // unassigned: the restart zeroes the watchdog but the prescaler keeps its count
        wr(`MCD_REG_WDCFG, 32'h2);
        repeat (64) @(posedge ref_clk);
        op(`MCD_OP_CLR_WDOG, 7'h00, 1'b0);
        rd(`MCD_REG_WDCNT, 32'h4000, 32'hc0f8);
        wr(`MCD_REG_WDCFG, 32'h0);
    endtask

    task automatic t_bad_access;
        wr(32'h1c, 32'h1, `MCD_RESP_SLVERR);
        wr(32'h02, 32'h1, `MCD_RESP_SLVERR);
        wr(`MCD_REG_WDCNT, 32'h55);
        rd(32'h1c, 32'h0, 32'hffffffff, `MCD_RESP_SLVERR);
        rd(32'h06, 32'h0, 32'hffffffff, `MCD_RESP_SLVERR);
        // a write without byte lane 0 must leave the working register alone
        s_axi_wstrb <= 4'he;
        wr(`MCD_REG_WORK, 32'h77);
        s_axi_wstrb <= 4'hf;
        rd(`MCD_REG_WORK, 32'hff);
    endtask

    // ********
    // main sequence
    // ********
    initial
    begin
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr} <= 96'h0;
        s_axi_wstrb <= 4'hf;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= 5'h0;
        repeat (2) @(posedge ref_clk);
        rstn <= 1'b1;
        t_reset();
        t_clear();
        t_complement();
        t_decrement();
        t_compare();
        t_watchdog();
        t_bad_access();
        give_verdict();
    end
endmodule // mcu_clear_compare_decrement_ops_test
`default_nettype wire
